// file: include/gss_pkg.sv
// Function
// RQ1 - No shadow sets: guest set accesses trap
// RQ2 - Root-only sets: guest HIGHEST_SET_FIELD reads zero, ignored
// RQ3 - Guest sets off: guest uses root current set
// RQ4 - Shared sets: guest control accesses trap
// RQ5 - Shared: previous-set moves ok, PREVIOUS_SET_FIELD writes trap
// RQ6 - Shared: root may write guest highest set
// RQ7 - Guest range is lowest to lowest plus highest
// RQ8 - Offset guest exception/previous sets by lowest
// RQ9 - Capture controller virtual set, then offset it
// RQ10 - Controller supplies sets inside guest range
// RQ11 - Guest sets on when highest set above zero
// RQ12 - Active set per mode and guest enable
// RQ13 - Previous set per mode; guest-off moves trap
// RQ14 - Root exception shifts root current to previous
// RQ15 - Guest exception shifts guest current to previous
// RQ16 - Exception return restores current from previous
// RQ17 - One multiply result pair for both contexts
// RQ18 - DSP: guest enable first, then root
// RQ19 - Guest DSP enable follows DSP present bit
// RQ20 - FPU: guest usable first, then root
// RQ21 - Coprocessor 2: guest usable first, then root
// RQ22 - SIMD: guest enable first, then root
// RQ23 - Both checks pass: no exception
`default_nettype none
package gss_pkg;
  localparam int SW = 4;
  localparam int AW = 8;
  typedef logic [3:0] gss_set_t;
  typedef logic [7:0] gss_addr_t;
  // Field order gives bit positions: css 3:0 up to hss 19:16.
  typedef struct packed {
    gss_set_t highest_set_field;
    gss_set_t irq_controller_set_field;
    gss_set_t exception_set_field;
    gss_set_t previous_set_field;
    gss_set_t current_set_field;
  } gss_srs_s;
  localparam int SRS_W = 20;
  localparam gss_addr_t ADR_ROOT_SRS = 8'h00;
  localparam gss_addr_t ADR_GUEST_SRS = 8'h04;
  localparam gss_addr_t ADR_ROOT_MAP = 8'h08;
  localparam gss_addr_t ADR_GUEST_MAP = 8'h0c;
  localparam gss_addr_t ADR_VCTL3 = 8'h10;
  localparam gss_addr_t ADR_UNITS = 8'h14;
  localparam gss_addr_t ADR_STATUS = 8'h18;
  localparam gss_addr_t ADR_MUL_LO = 8'h1c;
  localparam gss_addr_t ADR_MUL_HI = 8'h20;
  localparam int U_G_MX = 0;
  localparam int U_R_MX = 1;
  localparam int U_G_CU1 = 2;
  localparam int U_R_CU1 = 3;
  localparam int U_G_CU2 = 4;
  localparam int U_R_CU2 = 5;
  localparam int U_G_SIMD = 6;
  localparam int U_R_SIMD = 7;
  localparam int U_DSP_PRESENT_BIT = 8;
  localparam int UNITS_W = 9;
  localparam logic [8:0] UNITS_RST = 9'h000;
  localparam int ST_PREV_LSB = 4;
  localparam int ST_ON_BIT = 8;
  localparam gss_srs_s SRS_RST = '0;
  typedef enum logic [1:0] {
    GSS_NONE = 2'b00,
    GSS_ROOT_ONLY = 2'b01,
    GSS_SHARED = 2'b10
  } gss_case_e;
  typedef enum logic [1:0] {
    GSS_U_DSP = 2'b00,
    GSS_U_FPU = 2'b01,
    GSS_U_COP2 = 2'b10,
    GSS_U_SIMD = 2'b11
  } gss_unit_e;
  typedef enum logic [2:0] {
    GSS_X_NONE = 3'b000,
    GSS_X_DSP = 3'b001,
    GSS_X_COP = 3'b010,
    GSS_X_SIMD = 3'b011,
    GSS_X_PRIV = 3'b100
  } gss_exc_e;
  typedef enum logic [1:0] {
    GSS_SRC_ESS = 2'b00,
    GSS_SRC_EIC = 2'b01,
    GSS_SRC_MAP = 2'b10
  } gss_src_e;
endpackage
`default_nettype wire

// file: src/gss_core.sv
`default_nettype none
module gss_core #(
  parameter gss_pkg::gss_case_e SRS_CASE = gss_pkg::GSS_SHARED,
  parameter gss_pkg::gss_set_t ROOT_HSS = 4'hf
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire gss_pkg::gss_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic guest_mode,
  input wire logic exc_valid,
  input wire logic exc_in_guest,
  input wire gss_pkg::gss_src_e exc_src,
  input wire logic [2:0] exc_vec,
  input wire logic exception_return_valid,
  input wire logic eic_set_valid,
  input wire gss_pkg::gss_set_t eic_set,
  input wire logic g_ctl_acc,
  input wire logic g_pgpr_use,
  input wire logic g_pss_wr,
  input wire logic unit_req_valid,
  input wire gss_pkg::gss_unit_e unit_req,
  input wire logic mul_we,
  input wire logic [63:0] mul_res,
  output gss_pkg::gss_set_t active_set,
  output gss_pkg::gss_set_t prev_set,
  output logic guest_privileged_sensitive_exc,
  output gss_pkg::gss_exc_e unit_exc,
  output logic unit_exc_root,
  output logic unit_ok
);

  // ****************************************
  // Shadow set state
  // ****************************************
  gss_pkg::gss_srs_s root_q;
  gss_pkg::gss_srs_s guest_q;
  logic [31:0] rmap_q;
  logic [31:0] gmap_q;
  gss_pkg::gss_set_t guest_lowest_set_field_q;
  logic [gss_pkg::UNITS_W-1:0] units_q;
  logic [31:0] mul_lo_q;
  logic [31:0] mul_hi_q;
  logic gsrs_on;
  logic gexc;
  logic rexc;
  gss_pkg::gss_set_t rtarget;
  gss_pkg::gss_set_t gtarget;
  gss_pkg::gss_set_t act_d;
  gss_pkg::gss_set_t prev_d;
  logic wr_rsrs;
  logic wr_gsrs;
  logic guest_srs_live;

  assign wr_rsrs = reg_we && reg_addr == gss_pkg::ADR_ROOT_SRS;
  assign wr_gsrs = reg_we && reg_addr == gss_pkg::ADR_GUEST_SRS;
  // Only the shared case backs the guest control with real storage.
  assign guest_srs_live = SRS_CASE == gss_pkg::GSS_SHARED;
  assign gsrs_on = guest_q.highest_set_field != 4'h0; // RQ11
  assign rexc = exc_valid && !exc_in_guest;
  assign gexc = exc_valid && exc_in_guest && gsrs_on;

  always_comb begin
    unique case (exc_src)
      gss_pkg::GSS_SRC_EIC: rtarget = root_q.irq_controller_set_field;
      gss_pkg::GSS_SRC_MAP: rtarget = rmap_q[exc_vec*4 +: 4];
      default: rtarget = root_q.exception_set_field;
    endcase
  end

  always_comb begin
    unique case (exc_src)
      gss_pkg::GSS_SRC_EIC: gtarget = guest_q.irq_controller_set_field;
      gss_pkg::GSS_SRC_MAP: gtarget = gmap_q[exc_vec*4 +: 4];
      default: gtarget = guest_q.exception_set_field;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      root_q <= gss_pkg::SRS_RST;
    end else if (ce) begin
      if (wr_rsrs) begin
        root_q.irq_controller_set_field <= reg_wdata[15:12];
        root_q.exception_set_field <= reg_wdata[11:8];
        root_q.previous_set_field <= reg_wdata[7:4];
      end
      if (rexc) begin
        root_q.previous_set_field <= root_q.current_set_field; // RQ14
        root_q.current_set_field <= rtarget; // RQ14
      end else if (exception_return_valid && !guest_mode) begin
        root_q.current_set_field <= root_q.previous_set_field; // RQ16
      end
    end
  end

  // Writes from root land only when the guest copy really exists.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      guest_q <= gss_pkg::SRS_RST;
    end else if (ce && guest_srs_live) begin
      if (wr_gsrs) begin // RQ2
        guest_q.highest_set_field <= reg_wdata[19:16]; // RQ6
        guest_q.irq_controller_set_field <= reg_wdata[15:12];
        guest_q.exception_set_field <= reg_wdata[11:8];
        guest_q.previous_set_field <= reg_wdata[7:4];
      end
      if (eic_set_valid) begin
        guest_q.irq_controller_set_field <= eic_set; // RQ9
      end
      if (gexc) begin
        guest_q.previous_set_field <= guest_q.current_set_field; // RQ15
        guest_q.current_set_field <= gtarget; // RQ15
      end else if (exception_return_valid && guest_mode && gsrs_on) begin
        guest_q.current_set_field <= guest_q.previous_set_field; // RQ16
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rmap_q <= 32'h0000_0000;
      gmap_q <= 32'h0000_0000;
      guest_lowest_set_field_q <= 4'h0;
    end else if (ce && reg_we) begin
      if (reg_addr == gss_pkg::ADR_ROOT_MAP) begin
        rmap_q <= reg_wdata;
      end
      if (reg_addr == gss_pkg::ADR_GUEST_MAP && guest_srs_live) begin
        gmap_q <= reg_wdata;
      end
      if (reg_addr == gss_pkg::ADR_VCTL3) begin
        guest_lowest_set_field_q <= reg_wdata[3:0];
      end
    end
  end

  // ****************************************
  // Physical set selection
  // ****************************************
  // Sums wrap in the set width; keeping the guest range inside the
  // implemented sets is software's duty.
  always_comb begin
    if (guest_mode && gsrs_on) begin
      act_d = guest_q.current_set_field + guest_lowest_set_field_q; // RQ12 RQ7 RQ8
      prev_d = guest_q.previous_set_field + guest_lowest_set_field_q; // RQ13 RQ8
    end else if (guest_mode) begin
      act_d = root_q.current_set_field; // RQ3
      prev_d = root_q.previous_set_field;
    end else begin
      act_d = root_q.current_set_field; // RQ12
      prev_d = root_q.previous_set_field; // RQ13
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active_set <= 4'h0;
      prev_set <= 4'h0;
    end else if (ce) begin
      active_set <= act_d;
      prev_set <= prev_d;
    end
  end

  // ****************************************
  // Guest privileged sensitive checks
  // ****************************************
  logic guest_privileged_sensitive_exc_d;

  always_comb begin
    guest_privileged_sensitive_exc_d = 1'b0;
    if (g_ctl_acc || g_pss_wr) begin
      guest_privileged_sensitive_exc_d = 1'b1; // RQ1 RQ4 RQ5
    end
    if (g_pgpr_use && !(guest_srs_live && gsrs_on)) begin
      guest_privileged_sensitive_exc_d = 1'b1; // RQ1 RQ13
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      guest_privileged_sensitive_exc <= 1'b0;
    end else if (ce) begin
      guest_privileged_sensitive_exc <= guest_privileged_sensitive_exc_d;
    end
  end

  // ****************************************
  // Shared unit gating
  // ****************************************
  logic g_en;
  logic r_en;
  gss_pkg::gss_exc_e kind;

  always_comb begin
    unique case (unit_req)
      gss_pkg::GSS_U_DSP: begin
        g_en = units_q[gss_pkg::U_G_MX]; // RQ18
        r_en = units_q[gss_pkg::U_R_MX];
        kind = gss_pkg::GSS_X_DSP;
      end
      gss_pkg::GSS_U_FPU: begin
        g_en = units_q[gss_pkg::U_G_CU1]; // RQ20
        r_en = units_q[gss_pkg::U_R_CU1];
        kind = gss_pkg::GSS_X_COP;
      end
      gss_pkg::GSS_U_COP2: begin
        g_en = units_q[gss_pkg::U_G_CU2]; // RQ21
        r_en = units_q[gss_pkg::U_R_CU2];
        kind = gss_pkg::GSS_X_COP;
      end
      gss_pkg::GSS_U_SIMD: begin
        g_en = units_q[gss_pkg::U_G_SIMD]; // RQ22
        r_en = units_q[gss_pkg::U_R_SIMD];
        kind = gss_pkg::GSS_X_SIMD;
      end
    endcase
  end

  // The guest bit only counts in guest mode; outside it the root bit
  // alone decides.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      unit_exc <= gss_pkg::GSS_X_NONE;
      unit_exc_root <= 1'b0;
      unit_ok <= 1'b0;
    end else if (ce) begin
      unit_exc <= gss_pkg::GSS_X_NONE;
      unit_exc_root <= 1'b0;
      unit_ok <= 1'b0;
      if (unit_req_valid) begin
        if (guest_mode && !g_en) begin
          unit_exc <= kind; // RQ18 RQ20 RQ21 RQ22
        end else if (!r_en) begin
          unit_exc <= kind; // RQ18 RQ20 RQ21 RQ22
          unit_exc_root <= 1'b1;
        end else begin
          unit_ok <= 1'b1; // RQ23
        end
      end
    end
  end

  // Guest DSP enable cannot be set while DSP is absent for the guest.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      units_q <= gss_pkg::UNITS_RST;
    end else if (ce && reg_we && reg_addr == gss_pkg::ADR_UNITS) begin
      units_q <= reg_wdata[gss_pkg::UNITS_W-1:0];
      units_q[gss_pkg::U_G_MX] <= reg_wdata[gss_pkg::U_G_MX]
        && reg_wdata[gss_pkg::U_DSP_PRESENT_BIT]; // RQ19
    end
  end

  // A single result pair, written by the multiplier or by software,
  // whichever context is running.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mul_lo_q <= 32'h0000_0000;
      mul_hi_q <= 32'h0000_0000;
    end else if (ce) begin
      if (mul_we) begin
        mul_lo_q <= mul_res[31:0]; // RQ17
        mul_hi_q <= mul_res[63:32]; // RQ17
      end else if (reg_we && reg_addr == gss_pkg::ADR_MUL_LO) begin
        mul_lo_q <= reg_wdata;
      end else if (reg_we && reg_addr == gss_pkg::ADR_MUL_HI) begin
        mul_hi_q <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [31:0] rd_d;
  gss_pkg::gss_srs_s rsrs_view;

  always_comb begin
    rsrs_view = root_q;
    rsrs_view.highest_set_field = ROOT_HSS;
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (reg_addr)
      gss_pkg::ADR_ROOT_SRS: rd_d = {12'h000, rsrs_view};
      gss_pkg::ADR_GUEST_SRS: begin
        if (guest_srs_live) begin
          rd_d = {12'h000, guest_q};
        end
      end
      gss_pkg::ADR_ROOT_MAP: rd_d = rmap_q;
      gss_pkg::ADR_GUEST_MAP: rd_d = gmap_q;
      gss_pkg::ADR_VCTL3: rd_d = {28'h0000000, guest_lowest_set_field_q};
      gss_pkg::ADR_UNITS: rd_d = {23'h000000, units_q};
      gss_pkg::ADR_STATUS: rd_d = {23'h000000, gsrs_on, prev_set,
                                   active_set};
      gss_pkg::ADR_MUL_LO: rd_d = mul_lo_q;
      gss_pkg::ADR_MUL_HI: rd_d = mul_hi_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_re ? rd_d : 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_root_exc;
    ce && rexc;
  endsequence

  sequence s_guest_exc;
    ce && gexc && guest_srs_live;
  endsequence

  a_none_pgpr_trap: assert property ( // RQ1
    ce && g_pgpr_use && SRS_CASE != gss_pkg::GSS_SHARED |=> guest_privileged_sensitive_exc)
    else $error("previous-set move without guest sets did not trap");

  a_root_hss_zero: assert property ( // RQ2
    ce && reg_re && reg_addr == gss_pkg::ADR_GUEST_SRS && !guest_srs_live
    |=> reg_rdata[19:16] == 4'h0)
    else $error("guest highest set not zero in root-only case");

  a_ctl_acc_trap: assert property ( // RQ4
    ce && g_ctl_acc |=> guest_privileged_sensitive_exc)
    else $error("guest control access did not trap");

  a_pgpr_pass: assert property ( // RQ5
    ce && g_pgpr_use && !g_ctl_acc && !g_pss_wr && guest_srs_live
    && gsrs_on |=> !guest_privileged_sensitive_exc)
    else $error("shared previous-set move trapped");

  a_active_guest: assert property ( // RQ12
    ce && guest_mode && gsrs_on
    |=> active_set == gss_pkg::gss_set_t'($past(guest_q.current_set_field)
        + $past(guest_lowest_set_field_q)))
    else $error("guest active set not offset by lowest set");

  a_shared_root_set: assert property ( // RQ3
    ce && guest_mode && !gsrs_on |=> active_set == $past(root_q.current_set_field))
    else $error("guest without sets not on root current set");

  a_root_exc_shift: assert property ( // RQ14
    s_root_exc |=> root_q.previous_set_field == $past(root_q.current_set_field)
                   && root_q.current_set_field == $past(rtarget))
    else $error("root exception did not shift current to previous");

  a_guest_exc_shift: assert property ( // RQ15
    s_guest_exc |=> guest_q.previous_set_field == $past(guest_q.current_set_field)
                    && guest_q.current_set_field == $past(gtarget))
    else $error("guest exception did not shift its sets");

  a_exception_return_root: assert property ( // RQ16
    ce && exception_return_valid && !guest_mode && !rexc
    |=> root_q.current_set_field == $past(root_q.previous_set_field))
    else $error("root return did not restore current set");

  a_unit_guest_first: assert property ( // RQ18
    ce && unit_req_valid && guest_mode && !g_en
    |=> unit_exc != gss_pkg::GSS_X_NONE && !unit_exc_root && !unit_ok)
    else $error("guest enable not checked first");

  a_unit_pass: assert property ( // RQ23
    ce && unit_req_valid && (g_en || !guest_mode) && r_en
    |=> unit_ok && unit_exc == gss_pkg::GSS_X_NONE)
    else $error("unit request with both enables did not pass");

  a_dsp_present: assert property ( // RQ19
    !units_q[gss_pkg::U_DSP_PRESENT_BIT] |-> !units_q[gss_pkg::U_G_MX])
    else $error("guest DSP enable set while DSP absent");

endmodule
`default_nettype wire

// file: verification/gss_eic_model.sv
`default_nettype none
module gss_eic_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req,
  input wire gss_pkg::gss_set_t vset,
  input wire gss_pkg::gss_set_t guest_hss,
  output gss_pkg::gss_set_t set_num,
  output logic set_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Root-managed interrupt controller, guest set supply
  // ****************************************************************
  // Outside a request the set lines toggle, so a design that samples
  // them late cannot see a stale but plausible number.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      set_valid <= 1'b0;
      set_num <= 4'h0;
    end else begin
      set_valid <= req;
      if (req) begin
        set_num <= (vset > guest_hss) ? guest_hss : vset;
      end else begin
        set_num <= ~set_num;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [8:0] units;
    logic gm;
    gss_pkg::gss_unit_e unit;
    gss_pkg::gss_exc_e exc;
    logic root;
    logic ok;
  } gss_row_s;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  gss_pkg::gss_addr_t reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic guest_mode = 1'b0;
  logic exc_in_guest = 1'b0;
  gss_pkg::gss_src_e exc_src = gss_pkg::GSS_SRC_ESS;
  logic [2:0] exc_vec = 3'h0;
  logic [7:0] evs = 8'h00;
  gss_pkg::gss_set_t eic_vset = 4'h0;
  gss_pkg::gss_set_t g_hss = 4'h0;
  gss_pkg::gss_set_t eic_set;
  gss_pkg::gss_set_t active_set;
  gss_pkg::gss_set_t prev_set;
  logic eic_set_valid;
  gss_pkg::gss_unit_e unit_req = gss_pkg::GSS_U_DSP;
  logic [63:0] mul_res = 64'h0;
  logic guest_privileged_sensitive_exc;
  logic unit_exc_root;
  logic unit_ok;
  gss_pkg::gss_exc_e unit_exc;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  gss_row_s rows [12] = '{
    '{9'h000, 1, gss_pkg::GSS_U_DSP, gss_pkg::GSS_X_DSP, 0, 0},
    '{9'h001, 1, gss_pkg::GSS_U_DSP, gss_pkg::GSS_X_DSP, 0, 0},
    '{9'h101, 1, gss_pkg::GSS_U_DSP, gss_pkg::GSS_X_DSP, 1, 0},
    '{9'h103, 1, gss_pkg::GSS_U_DSP, gss_pkg::GSS_X_NONE, 0, 1},
    '{9'h000, 1, gss_pkg::GSS_U_FPU, gss_pkg::GSS_X_COP, 0, 0},
    '{9'h004, 1, gss_pkg::GSS_U_FPU, gss_pkg::GSS_X_COP, 1, 0},
    '{9'h00c, 1, gss_pkg::GSS_U_FPU, gss_pkg::GSS_X_NONE, 0, 1},
    '{9'h010, 1, gss_pkg::GSS_U_COP2, gss_pkg::GSS_X_COP, 1, 0},
    '{9'h030, 1, gss_pkg::GSS_U_COP2, gss_pkg::GSS_X_NONE, 0, 1},
    '{9'h040, 1, gss_pkg::GSS_U_SIMD, gss_pkg::GSS_X_SIMD, 1, 0},
    '{9'h0c0, 1, gss_pkg::GSS_U_SIMD, gss_pkg::GSS_X_NONE, 0, 1},
    '{9'h005, 0, gss_pkg::GSS_U_FPU, gss_pkg::GSS_X_COP, 1, 0}
  };

  gss_eic_model eic_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .req(evs[7]),
    .vset(eic_vset),
    .guest_hss(g_hss),
    .set_num(eic_set),
    .set_valid(eic_set_valid)
  );

  gss_core dut_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_re(reg_re),
    .reg_rdata(reg_rdata),
    .guest_mode(guest_mode),
    .exc_valid(evs[0]),
    .exc_in_guest(exc_in_guest),
    .exc_src(exc_src),
    .exc_vec(exc_vec),
    .exception_return_valid(evs[1]),
    .eic_set_valid(eic_set_valid),
    .eic_set(eic_set),
    .g_ctl_acc(evs[2]),
    .g_pgpr_use(evs[3]),
    .g_pss_wr(evs[4]),
    .unit_req_valid(evs[5]),
    .unit_req(unit_req),
    .mul_we(evs[6]),
    .mul_res(mul_res),
    .active_set(active_set),
    .prev_set(prev_set),
    .guest_privileged_sensitive_exc(guest_privileged_sensitive_exc),
    .unit_exc(unit_exc),
    .unit_exc_root(unit_exc_root),
    .unit_ok(unit_ok)
  );

  // ****************************************************************
  // Bus and event helpers
  // ****************************************************************
  always #2.5 sys_clk = ~sys_clk;

  task automatic summarize();
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The ceiling is more than ten times the length of the whole sequence.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(gss_pkg::gss_addr_t a, logic [31:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(gss_pkg::gss_addr_t a, logic [31:0] e);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask

  // Single-cycle pulse on one event input; returns in the answer cycle.
  task automatic pulse(int i);
    @(posedge sys_clk);
    evs[i] <= 1'b1;
    @(posedge sys_clk);
    evs <= 8'h00;
    @(negedge sys_clk);
  endtask

  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic sets(logic [3:0] act, logic [3:0] prv);
    settle();
    chk({prev_set, active_set}, {prv, act});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    chk({guest_privileged_sensitive_exc, unit_ok, prev_set, active_set}, 32'h0);
    resetn <= 1'b1;
    rd(gss_pkg::ADR_UNITS, 32'h0);
    rd(8'h30, 32'h0);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      guest_mode <= rows[i].gm;
      unit_req <= rows[i].unit;
      wr(gss_pkg::ADR_UNITS, {23'h0, rows[i].units});
      pulse(5);
      chk({unit_exc, unit_exc_root, unit_ok}, rows[i][4:0]);
    end
    rd(gss_pkg::ADR_UNITS, 32'h004);
    // Guest window at sets 3..5 in the shared arrangement.
    @(posedge sys_clk);
    guest_mode <= 1'b1;
    exc_in_guest <= 1'b1;
    g_hss <= 4'h2;
    wr(gss_pkg::ADR_VCTL3, 32'h3);
    wr(gss_pkg::ADR_GUEST_SRS, 32'h0002_0100);
    rd(gss_pkg::ADR_GUEST_SRS, 32'h0002_0100);
    sets(4'h3, 4'h3);
    rd(gss_pkg::ADR_STATUS, 32'h133);
    pulse(3);
    chk(guest_privileged_sensitive_exc, 1'b0);
    pulse(4);
    chk(guest_privileged_sensitive_exc, 1'b1);
    pulse(2);
    chk(guest_privileged_sensitive_exc, 1'b1);
    pulse(0);
    sets(4'h4, 4'h3);
    pulse(1);
    sets(4'h3, 4'h3);
    eic_vset <= 4'h2;
    pulse(7);
    exc_src <= gss_pkg::GSS_SRC_EIC;
    pulse(0);
    sets(4'h5, 4'h3);
    wr(gss_pkg::ADR_GUEST_MAP, 32'h100);
    exc_src <= gss_pkg::GSS_SRC_MAP;
    exc_vec <= 3'h2;
    pulse(0);
    sets(4'h4, 4'h5);
    // Guest sets switched off: guest falls back to the root set.
    g_hss <= 4'h0;
    wr(gss_pkg::ADR_GUEST_SRS, 32'h0);
    sets(4'h0, 4'h0);
    pulse(3);
    chk(guest_privileged_sensitive_exc, 1'b1);
    pulse(0);
    sets(4'h0, 4'h0);
    @(posedge sys_clk);
    guest_mode <= 1'b0;
    exc_in_guest <= 1'b0;
    exc_src <= gss_pkg::GSS_SRC_ESS;
    wr(gss_pkg::ADR_ROOT_SRS, 32'h0000_0500);
    pulse(0);
    sets(4'h5, 4'h0);
    pulse(1);
    sets(4'h0, 4'h0);
    ce <= 1'b0;
    pulse(0);
    sets(4'h0, 4'h0);
    ce <= 1'b1;
    mul_res <= 64'h89ab_cdef_0123_4567;
    pulse(6);
    rd(gss_pkg::ADR_MUL_LO, 32'h0123_4567);
    rd(gss_pkg::ADR_MUL_HI, 32'h89ab_cdef);
    wr(gss_pkg::ADR_MUL_LO, 32'h5a5a_0f0f);
    rd(gss_pkg::ADR_MUL_LO, 32'h5a5a_0f0f);
    summarize();
  end
endmodule
`default_nettype wire
